/* File: logic/acd_cmd_layer.sv */
// Purpose: Device command layer: task file, command decode, DMA data-in.
// Assumes: Media stager and transport are logic on ref_clk.
// Notes: APB answers with one access cycle; irq is a level.
//
// What this block does
// - DMA-in command enters prepare state, stages data.
// - Prepare moves to send-data when frame ready.
// - Prepare moves to send-status when done or aborted.
// - Send-data requests frames of at most 2048 dwords.
// - Frame sent returns send-data to prepare.
// - Send-status sends Register FIS, interrupt bit set.
// - Status FIS sent returns to idle.
// - Legacy codes complete as no-operations.
// - F8h and 27h read native maximum address.
// - 40h/41h verify, 42h extended verify.
// - HOB bit selects upper or lower readback byte.
// - Drive-only commands ignore the head field.
// - Full-use commands take drive and head.
`timescale 1ns/10ps
module acd_cmd_layer
   import acd_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Media stager
   output logic stage_req,
   input wire logic stage_ready,
   input wire logic media_error,
   // Transport data frame request
   output logic tx_data_req,
   output logic [11:0] tx_data_dwords,
   input wire logic tx_data_done,
   // Transport Register FIS request
   output logic tx_reg_req,
   output acd_reg_fis_t tx_reg_fis,
   input wire logic tx_reg_done,
   // Interrupt
   output logic irq
);

   // ==========================================================
   // Declarations
   logic [15:0] tf [0:4];
   logic [7:0] drv_head;
   logic [7:0] devctl;
   logic [7:0] cmd_code;
   logic [2:0] istat;
   logic [2:0] imask;
   logic [2:0] ev;
   logic last_abort;
   logic [23:0] remaining;
   acd_state_t state;
   acd_cmd_info_t dec;
   acd_cmd_info_t cur;
   logic setup;
   logic acc_wr;
   logic acc_rd;
   logic [31:0] rd_val;
   logic rd_ok;
   logic cmd_wr;
   logic [2:0] next_istat;

   // ==========================================================
   // Functions
   // Sector count to dwords; a zero count means the largest count.
   function automatic logic [23:0] sect_dw(input logic ext, input logic [15:0] c);
      logic [16:0] s;
      s = ext ? {1'b0, c} : {9'h000, c[7:0]};
      if (s == 17'h00000) begin
         s = ext ? 17'h10000 : 17'h00100;
      end
      return {s, 7'h00};
   endfunction

   // Next frame length, capped at the frame ceiling.
   function automatic logic [11:0] frame_len(input logic [23:0] r);
      if (r > {12'h000, ACD_MAX_FRAME_DW}) begin
         return ACD_MAX_FRAME_DW;
      end
      return r[11:0];
   endfunction

   // Byte of a 16-bit parameter register picked by the HOB bit.
   function automatic logic [7:0] hob_byte(input logic [15:0] v, input logic hob);
      return hob ? v[15:8] : v[7:0];
   endfunction

   // ==========================================================
   // Decoder
   acd_cmd_decode u_dec (
      .cmd(pwdata[7:0]),
      .info(dec)
   );

   // ==========================================================
   // APB phase decode
   assign setup = psel && !penable;
   assign acc_wr = psel && penable && pready && pwrite;
   assign acc_rd = psel && penable && pready && !pwrite;
   assign cmd_wr = acc_wr && (paddr == ACD_OFS_CMD);

   // Read mux; unmapped addresses answer with an error.
   always_comb begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      unique case (paddr)
         ACD_OFS_FEAT: rd_val = {24'h000000, hob_byte(tf[0], devctl[ACD_HOB_BIT])};
         ACD_OFS_SCNT: rd_val = {24'h000000, hob_byte(tf[1], devctl[ACD_HOB_BIT])};
         ACD_OFS_SNUM: rd_val = {24'h000000, hob_byte(tf[2], devctl[ACD_HOB_BIT])};
         ACD_OFS_CYLLO: rd_val = {24'h000000, hob_byte(tf[3], devctl[ACD_HOB_BIT])};
         ACD_OFS_CYLHI: rd_val = {24'h000000, hob_byte(tf[4], devctl[ACD_HOB_BIT])};
         ACD_OFS_DRVHD: rd_val = {24'h000000, drv_head};
         ACD_OFS_CMD: rd_val = {24'h000000, cmd_code};
         ACD_OFS_DEVCTL: rd_val = {24'h000000, devctl};
         ACD_OFS_STATUS: rd_val = {29'h00000000, last_abort, state};
         ACD_OFS_ISTAT: rd_val = {29'h00000000, istat};
         ACD_OFS_IMASK: rd_val = {29'h00000000, imask};
         default: rd_ok = 1'b0;
      endcase
   end

   // Answer registered in the setup cycle, so outputs come from flops.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !rd_ok;
         if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_val;
         end
      end
   end

   // ==========================================================
   // Task file: each write shifts the old low byte into the high byte.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < 5; i++) begin
            tf[i] <= ACD_TF_RST;
         end
      end else if (acc_wr) begin
         for (int i = 0; i < 5; i++) begin
            if (paddr == 8'(4 * i)) begin
               tf[i] <= {tf[i][7:0], pwdata[7:0]};
            end
         end
      end
   end

   // Control bytes and the mask.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         drv_head <= ACD_BYTE_RST;
         devctl <= ACD_BYTE_RST;
         imask <= ACD_MASK_RST;
      end else if (acc_wr) begin
         if (paddr == ACD_OFS_DRVHD) drv_head <= pwdata[7:0];
         if (paddr == ACD_OFS_DEVCTL) devctl <= pwdata[7:0];
         if (paddr == ACD_OFS_IMASK) imask <= pwdata[2:0];
      end
   end

   // ==========================================================
   // Command flow. A command written while busy is dropped; the host
   // must wait for the closing interrupt before issuing the next one.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= device_idle_state;
         cmd_code <= ACD_BYTE_RST;
         cur <= '0;
         remaining <= 24'h000000;
         last_abort <= 1'b0;
         stage_req <= 1'b0;
         tx_data_req <= 1'b0;
         tx_data_dwords <= 12'h000;
         tx_reg_req <= 1'b0;
         tx_reg_fis <= '0;
         ev <= 3'h0;
      end else begin
         ev <= 3'h0;
         unique case (state)
            device_idle_state: begin
               if (cmd_wr) begin
                  cmd_code <= pwdata[7:0];
                  cur <= dec;
                  if (dec.cls == cls_dma_in) begin
                     state <= dma_in_prepare_state;
                     remaining <= sect_dw(dec.ext, dec.cnt_feat ? tf[0] : tf[1]);
                     stage_req <= 1'b1;
                  end else begin
                     state <= dma_in_send_status_state;
                     tx_reg_req <= 1'b1;
                     last_abort <= (dec.cls == cls_abort);
                     tx_reg_fis.status <= (dec.cls == cls_abort) ? ACD_ST_ERR : ACD_ST_OK;
                     tx_reg_fis.error <= (dec.cls == cls_abort) ? ACD_ER_ABRT : ACD_ER_NONE;
                     tx_reg_fis.ibit <= 1'b1;
                     // Full-use codes keep the head, others only drive.
                     tx_reg_fis.device <= dec.dh_full ? (drv_head | ACD_DEV_FIXED)
                        : (ACD_DEV_FIXED | {3'h0, drv_head[ACD_DRV_BIT], 4'h0});
                  end
               end
            end
            dma_in_prepare_state: begin
               if (remaining == 24'h000000 || media_error) begin
                  state <= dma_in_send_status_state;
                  stage_req <= 1'b0;
                  tx_reg_req <= 1'b1;
                  last_abort <= media_error && remaining != 24'h000000;
                  if (remaining != 24'h000000) begin
                     tx_reg_fis.status <= ACD_ST_ERR;
                     tx_reg_fis.error <= ACD_ER_ABRT;
                  end else begin
                     tx_reg_fis.status <= ACD_ST_OK;
                     tx_reg_fis.error <= ACD_ER_NONE;
                  end
                  tx_reg_fis.ibit <= 1'b1;
                  tx_reg_fis.device <= cur.dh_full ? (drv_head | ACD_DEV_FIXED)
                     : (ACD_DEV_FIXED | {3'h0, drv_head[ACD_DRV_BIT], 4'h0});
               end else if (stage_ready) begin
                  state <= dma_in_send_data_state;
                  stage_req <= 1'b0;
                  tx_data_req <= 1'b1;
                  tx_data_dwords <= frame_len(remaining);
               end
            end
            dma_in_send_data_state: begin
               if (tx_data_done) begin
                  state <= dma_in_prepare_state;
                  tx_data_req <= 1'b0;
                  remaining <= remaining - {12'h000, tx_data_dwords};
                  stage_req <= (remaining != {12'h000, tx_data_dwords});
                  ev[ACD_EV_FRAME] <= 1'b1;
               end
            end
            dma_in_send_status_state: begin
               if (tx_reg_done) begin
                  state <= device_idle_state;
                  tx_reg_req <= 1'b0;
                  ev[ACD_EV_DONE] <= 1'b1;
                  ev[ACD_EV_ABORT] <= last_abort;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Interrupt status: a read clears, a same-cycle event still wins.
   assign next_istat = (acc_rd && paddr == ACD_OFS_ISTAT) ? ev : (istat | ev);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         istat <= 3'h0;
         irq <= 1'b0;
      end else begin
         istat <= next_istat;
         irq <= |(istat & imask);
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_frame_sent;
      state == dma_in_send_data_state && tx_data_done;
   endsequence

   sequence s_status_sent;
      tx_reg_req && tx_reg_done;
   endsequence

   a_dma_entry: assert property (state == device_idle_state && cmd_wr &&
      dec.cls == cls_dma_in |=> state == dma_in_prepare_state && stage_req)
      else $error("dma-in command did not enter prepare");
   a_frame_ready: assert property (state == dma_in_prepare_state && !media_error &&
      remaining != 24'h000000 && stage_ready |=> tx_data_req && !stage_req)
      else $error("ready frame not sent");
   a_done_status: assert property (state == dma_in_prepare_state &&
      remaining == 24'h000000 |=> tx_reg_req && tx_reg_fis.status == ACD_ST_OK)
      else $error("finished transfer did not close");
   a_frame_limit: assert property (tx_data_req |-> tx_data_dwords != 12'h000 &&
      tx_data_dwords <= ACD_MAX_FRAME_DW)
      else $error("frame size out of range");
   a_frame_return: assert property (s_frame_sent |=> state == dma_in_prepare_state &&
      !tx_data_req && remaining == $past(remaining) - {12'h000, $past(tx_data_dwords)})
      else $error("frame completion mishandled");
   a_status_ibit: assert property (tx_reg_req |-> tx_reg_fis.ibit)
      else $error("status frame lacks interrupt bit");
   a_status_exit: assert property (s_status_sent |=> state == device_idle_state
      ##1 istat[ACD_EV_DONE])
      else $error("status completion mishandled");
   a_abort_report: assert property (state == dma_in_prepare_state && media_error &&
      remaining != 24'h000000 |=> tx_reg_fis.error == ACD_ER_ABRT)
      else $error("abort not reported");
   a_unknown_abort: assert property (state == device_idle_state && cmd_wr &&
      pwdata[7:0] == 8'hFF |=> tx_reg_fis.error == ACD_ER_ABRT)
      else $error("unknown code not aborted");
   a_hob_read: assert property (setup && !pwrite && paddr == ACD_OFS_SCNT &&
      devctl[ACD_HOB_BIT] |=> prdata[7:0] == $past(tf[1][15:8]))
      else $error("hob readback wrong");
   a_double_write: assert property (acc_wr && paddr == ACD_OFS_SCNT |=>
      tf[1] == {$past(tf[1][7:0]), $past(pwdata[7:0])})
      else $error("parameter byte lost");

   // Housekeeping checks: busy writes, device byte, interrupt level and read-to-clear.
   a_busy_drop: assert property (state != device_idle_state && cmd_wr |=>
      cmd_code == $past(cmd_code))
      else $error("command accepted while busy");
   a_drive_only: assert property (state == device_idle_state && cmd_wr &&
      pwdata[7:0] == 8'hEC |=> tx_reg_fis.device ==
      (ACD_DEV_FIXED | {3'h0, $past(drv_head[ACD_DRV_BIT]), 4'h0}))
      else $error("drive-only device byte wrong");
   a_full_use: assert property (state == device_idle_state && cmd_wr &&
      pwdata[7:0] == 8'h40 |=> tx_reg_fis.device == (ACD_DEV_FIXED | $past(drv_head)))
      else $error("full-use device byte wrong");
   a_irq_raise: assert property ((istat & imask) != 3'h0 |=> irq)
      else $error("interrupt not raised");
   a_irq_drop: assert property ((istat & imask) == 3'h0 |=> !irq)
      else $error("interrupt raised without cause");
   a_read_clear: assert property (acc_rd && paddr == ACD_OFS_ISTAT |=>
      istat == $past(ev))
      else $error("status read did not clear");

endmodule // acd_cmd_layer

/* File: common/acd_pkg.sv */
// Purpose: Shared constants and types for the command and DMA data-in layer.
// Assumes: One 10 MHz clock, synchronous active-high reset.
// Notes: Register offsets are byte addresses on a 32-bit APB.
package acd_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] ACD_OFS_FEAT = 8'h00;
   localparam logic [7:0] ACD_OFS_SCNT = 8'h04;
   localparam logic [7:0] ACD_OFS_SNUM = 8'h08;
   localparam logic [7:0] ACD_OFS_CYLLO = 8'h0C;
   localparam logic [7:0] ACD_OFS_CYLHI = 8'h10;
   localparam logic [7:0] ACD_OFS_DRVHD = 8'h14;
   localparam logic [7:0] ACD_OFS_CMD = 8'h18;
   localparam logic [7:0] ACD_OFS_DEVCTL = 8'h1C;
   localparam logic [7:0] ACD_OFS_STATUS = 8'h20;
   localparam logic [7:0] ACD_OFS_ISTAT = 8'h24;
   localparam logic [7:0] ACD_OFS_IMASK = 8'h28;

   // ==========================================================
   // Field positions and values
   localparam int ACD_HOB_BIT = 7;
   localparam int ACD_DRV_BIT = 4;
   localparam int ACD_EV_DONE = 0;
   localparam int ACD_EV_ABORT = 1;
   localparam int ACD_EV_FRAME = 2;
   localparam logic [7:0] ACD_ST_OK = 8'h50;
   localparam logic [7:0] ACD_ST_ERR = 8'h51;
   localparam logic [7:0] ACD_ER_ABRT = 8'h04;
   localparam logic [7:0] ACD_ER_NONE = 8'h00;
   localparam logic [7:0] ACD_DEV_FIXED = 8'hA0;
   localparam logic [15:0] ACD_TF_RST = 16'h0000;
   localparam logic [7:0] ACD_BYTE_RST = 8'h00;
   localparam logic [2:0] ACD_MASK_RST = 3'h0;

   // ==========================================================
   // Frame sizing: one data frame carries at most this many dwords.
   localparam logic [11:0] ACD_MAX_FRAME_DW = 12'h800;
   localparam int ACD_DW_PER_SECT_SH = 7;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      cls_abort,
      cls_nop,
      cls_nodata,
      cls_dma_in
   } acd_cls_t;

   typedef struct packed {
      acd_cls_t cls;
      logic ext;
      logic dh_full;
      logic cnt_feat;
   } acd_cmd_info_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] error;
      logic [7:0] device;
      logic ibit;
   } acd_reg_fis_t;

   typedef enum logic [1:0] {
      device_idle_state,
      dma_in_prepare_state,
      dma_in_send_data_state,
      dma_in_send_status_state
   } acd_state_t;

endpackage

/* File: logic/acd_cmd_decode.sv */
// Purpose: Classifies an operation code into its handling class.
// Assumes: Pure combinational, fed from the command write data.
// Notes: Unknown codes fall to the abort class.
`timescale 1ns/10ps
module acd_cmd_decode
   import acd_pkg::*;
(
   // Operation code in
   input wire logic [7:0] cmd,
   // Decoded class and parameter usage
   output acd_cmd_info_t info
);

   // ==========================================================
   // Decode table
   // Legacy codes finish as no-operations so old hosts still work.
   always_comb begin
      info = '0;
      info.cls = cls_abort;
      casez (cmd)
         // Recalibrate uses only the drive bit; seek and format take the head too.
         8'h1?, 8'h00: info.cls = cls_nop;
         8'h7?, 8'h50: begin
            info.cls = cls_nop;
            info.dh_full = 1'b1;
         end
         8'hC8: begin
            info.cls = cls_dma_in;
            info.dh_full = 1'b1;
         end
         8'h25: begin
            info.cls = cls_dma_in;
            info.ext = 1'b1;
         end
         8'h60: begin
            info.cls = cls_dma_in;
            info.ext = 1'b1;
            info.cnt_feat = 1'b1;
         end
         8'hF8: info.cls = cls_nodata;
         8'h27: begin
            info.cls = cls_nodata;
            info.ext = 1'b1;
         end
         8'h40, 8'h41: begin
            info.cls = cls_nodata;
            info.dh_full = 1'b1;
         end
         8'h42, 8'h61, 8'h35, 8'h37, 8'h29, 8'h24, 8'h39, 8'h34,
         8'h06, 8'hEA: begin
            info.cls = cls_nodata;
            info.ext = 1'b1;
         end
         8'hCA, 8'hCB, 8'hF9, 8'hC4, 8'h20, 8'hC5, 8'h30, 8'h3C: begin
            info.cls = cls_nodata;
            info.dh_full = 1'b1;
         end
         8'hEC, 8'hE5, 8'h98, 8'h90, 8'hE7, 8'hE3, 8'h97, 8'hE1,
         8'h95, 8'hDE, 8'hDF, 8'hE4, 8'hE8, 8'hEF, 8'hC6, 8'hE6,
         8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'hF1, 8'hF2, 8'hF3,
         8'hF4, 8'hF5, 8'hF6, 8'hB0: begin
            info.cls = cls_nodata;
         end
         default: info.cls = cls_abort;
      endcase
   end

endmodule // acd_cmd_decode

/* File: sim/acd_far_model.sv */
// Purpose: Behavioural media stager and transport partner for the command layer.
// Assumes: Same clock as the design; every request is a level held until answered.
// Notes: The wait before each answer is set by lat, so tests can run prompt or slow.
`timescale 1ns/10ps
module acd_far_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Bench controls
   input wire logic [3:0] lat,
   input wire logic err_en,
   // Requests from the design
   input wire logic stage_req,
   input wire logic tx_data_req,
   input wire logic tx_reg_req,
   // Answers to the design
   output logic stage_ready,
   output logic media_error,
   output logic tx_data_done,
   output logic tx_reg_done
);
   // ==========================================================
   // Answer timing
   logic [3:0] wait_cnt;
   logic data_ack;
   logic reg_ack;
   logic awaiting;
   logic fire;

   // Only one request is open at a time, so a single wait counter serves all three.
   assign awaiting = (stage_req && !stage_ready) || (tx_data_req && !data_ack)
      || (tx_reg_req && !reg_ack);
   assign fire = awaiting && (wait_cnt == lat);
   // A staging failure shows only while staging is being asked for.
   assign media_error = err_en && stage_req;

   // Counts the cycles an open request has waited.
   always_ff @(posedge ref_clk) begin
      if (srst || !awaiting || fire) begin
         wait_cnt <= 4'h0;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end

   // Staged data is used up as soon as the frame request appears.
   always_ff @(posedge ref_clk) begin
      if (srst || tx_data_req) begin
         stage_ready <= 1'b0;
      end else if (fire && stage_req) begin
         stage_ready <= 1'b1;
      end
   end

   // Done pulses last one cycle; the ack flags stop a second pulse while requests drop.
   always_ff @(posedge ref_clk) begin
      tx_data_done <= !srst && fire && tx_data_req;
      data_ack <= !srst && tx_data_req && (data_ack || fire);
      tx_reg_done <= !srst && fire && tx_reg_req;
      reg_ack <= !srst && tx_reg_req && (reg_ack || fire);
   end
endmodule // acd_far_model

/* File: sim/acd_cmd_layer_tb.sv */
// Purpose: Self-checking bench for the command layer over APB with a far-side model.
// Assumes: APB answers are awaited, never assumed; the model sets stage and send delays.
// Notes: Expected values come from the command table and the package constants.
`timescale 1ns/10ps
module acd_cmd_layer_tb
   import acd_pkg::*;
;
   // ==========================================================
   // Signals
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, stage_req, stage_ready, media_error, tx_data_req;
   logic [11:0] tx_data_dwords;
   logic tx_data_done, tx_reg_req, tx_reg_done, irq;
   acd_reg_fis_t tx_reg_fis;
   logic [3:0] lat = 4'h0;
   logic err_en = 1'b0;
   logic prev_data = 1'b0;
   logic prev_stage = 1'b0;
   int errors = 0;
   int checked = 0;
   int frames, dw_sum, stages, cycles = 0;
   logic [31:0] rd;
   logic er;
   logic [7:0] dev_y = ACD_DEV_FIXED | 8'h1F;
   logic [7:0] dev_d = ACD_DEV_FIXED | 8'h10;
   logic [7:0] nd_code [13] = '{8'hF8, 8'h27, 8'h40, 8'h41, 8'h42, 8'hEC, 8'h00,
      8'h10, 8'h70, 8'h50, 8'hCA, 8'h61, 8'hFF};
   logic nd_full [13] = '{0, 0, 1, 1, 0, 0, 0, 0, 1, 1, 1, 0, 0};

   // 100 ns clock.
   always #50 ref_clk = ~ref_clk;

   acd_cmd_layer i_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stage_req(stage_req), .stage_ready(stage_ready),
      .media_error(media_error), .tx_data_req(tx_data_req), .tx_data_dwords(tx_data_dwords),
      .tx_data_done(tx_data_done), .tx_reg_req(tx_reg_req), .tx_reg_fis(tx_reg_fis),
      .tx_reg_done(tx_reg_done), .irq(irq));

   acd_far_model i_far (.ref_clk(ref_clk), .srst(srst), .lat(lat), .err_en(err_en),
      .stage_req(stage_req), .tx_data_req(tx_data_req), .tx_reg_req(tx_reg_req),
      .stage_ready(stage_ready), .media_error(media_error), .tx_data_done(tx_data_done),
      .tx_reg_done(tx_reg_done));

   // ==========================================================
   // Checking and closing
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the longest command.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         finish_test();
      end
   end

   // Counts staging requests and frames; every frame must respect the size ceiling.
   always @(posedge ref_clk) begin
      prev_data <= tx_data_req;
      prev_stage <= stage_req;
      if (stage_req === 1'b1 && !prev_stage) begin
         stages++;
      end
      if (tx_data_req === 1'b1 && !prev_data) begin
         frames++;
         dw_sum += tx_data_dwords;
         check("frame size", {31'h0, tx_data_dwords <= ACD_MAX_FRAME_DW}, 32'h1);
      end
   end

   // ==========================================================
   // APB master: request held until pready is sampled high, then released.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      if (n >= 50) begin
         errors++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Issues one command and checks the closing frame, the data moved and the interrupt.
   task automatic run_cmd(input logic [7:0] code, input int dw, input int nfr,
      input logic [7:0] st, input logic [7:0] ec, input logic [7:0] dev,
      input logic [31:0] ist, input logic [31:0] ist_m, input logic poke);
      int n;
      frames = 0;
      dw_sum = 0;
      stages = 0;
      n = 0;
      apb(1'b1, ACD_OFS_CMD, {24'h0, code});
      if (poke) begin
         apb(1'b0, ACD_OFS_STATUS, 32'h0);
         check("state prepare", rd & 32'h3, 32'h1);
         apb(1'b1, ACD_OFS_CMD, 32'hEC);
      end
      while (tx_reg_req !== 1'b1 && n < 5000) begin
         @(posedge ref_clk);
         n++;
      end
      check("fis status", tx_reg_fis.status, st);
      check("fis error", tx_reg_fis.error, ec);
      check("fis ibit", tx_reg_fis.ibit, 1'b1);
      if (dev != 8'h00) begin
         check("fis device", tx_reg_fis.device, dev);
      end
      while (tx_reg_req === 1'b1 && n < 5000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 5000) begin
         errors++;
      end
      repeat (3) @(posedge ref_clk);
      check("irq raised", irq, 1'b1);
      apb(1'b0, ACD_OFS_STATUS, 32'h0);
      check("idle again", rd & 32'h3, 32'h0);
      apb(1'b0, ACD_OFS_ISTAT, 32'h0);
      check("events", rd & ist_m, ist);
      repeat (2) @(posedge ref_clk);
      check("irq cleared", irq, 1'b0);
      check("frames", frames, nfr);
      check("dwords", dw_sum, dw);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      apb(1'b0, ACD_OFS_STATUS, 32'h0);
      check("status reset", rd, 32'h0);
      apb(1'b0, ACD_OFS_IMASK, 32'h0);
      check("mask reset", rd, {29'h0, ACD_MASK_RST});
      apb(1'b1, 8'h3C, 32'h55);
      check("unmapped write err", er, 1'b1);
      apb(1'b0, 8'h3C, 32'h0);
      check("unmapped read err", er, 1'b1);
      check("unmapped data", rd, 32'h0);
      // Both bytes of every parameter register stay readable.
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 8'(4 * i), 32'h10 + i);
         apb(1'b1, 8'(4 * i), 32'h20 + i);
         apb(1'b1, ACD_OFS_DEVCTL, 32'h80);
         apb(1'b0, 8'(4 * i), 32'h0);
         check("upper byte", rd, 32'h10 + i);
         apb(1'b1, ACD_OFS_DEVCTL, 32'h00);
         apb(1'b0, 8'(4 * i), 32'h0);
         check("lower byte", rd, 32'h20 + i);
      end
      apb(1'b1, ACD_OFS_DRVHD, 32'h1F);
      apb(1'b1, ACD_OFS_IMASK, 32'h7);
      // 17 sectors split into a full frame and a remainder; a busy write is ignored.
      lat <= 4'h8;
      apb(1'b1, ACD_OFS_SCNT, 32'h00);
      apb(1'b1, ACD_OFS_SCNT, 32'h11);
      run_cmd(8'hC8, 2176, 2, ACD_ST_OK, ACD_ER_NONE, dev_y, 5, 7, 1);
      lat <= 4'h0;
      apb(1'b1, ACD_OFS_SCNT, 32'h00);
      apb(1'b1, ACD_OFS_SCNT, 32'h01);
      run_cmd(8'h25, 128, 1, ACD_ST_OK, ACD_ER_NONE, dev_d, 5, 7, 0);
      apb(1'b1, ACD_OFS_FEAT, 32'h00);
      apb(1'b1, ACD_OFS_FEAT, 32'h02);
      run_cmd(8'h60, 256, 1, ACD_ST_OK, ACD_ER_NONE, dev_d, 5, 7, 0);
      apb(1'b1, ACD_OFS_SCNT, 32'h00);
      run_cmd(8'hC8, 32768, 16, ACD_ST_OK, ACD_ER_NONE, dev_y, 5, 7, 0);
      // Staging failure ends the command early with an error status.
      err_en <= 1'b1;
      lat <= 4'h5;
      run_cmd(8'hC8, 0, 0, ACD_ST_ERR, ACD_ER_ABRT, dev_y, 3, 3, 0);
      err_en <= 1'b0;
      // Codes without a data phase complete at once and never ask for staging.
      for (int i = 0; i < 13; i++) begin
         if (i == 12) begin
            run_cmd(nd_code[i], 0, 0, ACD_ST_ERR, ACD_ER_ABRT, 8'h00, 1, 1, 0);
         end else begin
            run_cmd(nd_code[i], 0, 0, ACD_ST_OK, ACD_ER_NONE, nd_full[i] ? dev_y : dev_d,
               1, 1, 0);
         end
         check("no staging", stages, 0);
      end
      finish_test();
   end
endmodule // acd_cmd_layer_tb
